// ### hw/tbl_dmem.sv
// table-read sequencer and banked data memory of the core
`timescale 1ns/1ps
`default_nettype none

// How it works
// - a current-page table read takes the address bits above bit 7 from the program counter and the low byte from the table pointer.
// - a last-page table read forces every address bit above bit 7 to one and takes the low byte from the table pointer.
// - the table address is as wide as the program counter of the variant, 12, 11 or 10 bits.
// - every table read writes the low byte of the fetched word to the target location and the upper part to the table high byte.
// - the table high byte is read only and software writes leave it unchanged.
// - each table read takes two instruction cycles before it completes.
// - data memory is 8 bits wide from address 00H with special registers at fixed low addresses.
// - bank 1 holds only the eeprom access control register at 40H, and bank 0 holds everything else.
// - unused special locations, including the reserved gap before general memory, read as 00H.
// - protected special registers are read only, all others and all general locations are read and write.
// - single-bit set and clear change only the selected bit of a location.
// - data memory may also be reached indirectly through either memory pointer.
// - upper-byte bits the program word does not implement read as zero in the table high byte.
// - the 8-bit table pointer supplies the low eight table address bits for both table reads.
module tbl_dmem
  import tbl_dmem_pkg::*;
(
  input  wire logic            clk,          // instruction clock
  input  wire logic            arst_n,       // async reset, active low
  input  wire logic            clk_en,       // freezes all state when low
  input  wire logic [PC_W-1:0] pc,           // current program counter
  input  wire logic            tbl_rd,       // start a table read, one cycle
  input  wire logic            tbl_last,     // 1 = last page, 0 = current page
  input  wire logic [7:0]      tbl_dst,      // target data address of the read
  output logic      [PC_W-1:0] pm_addr,      // program memory address
  input  wire logic [PM_W-1:0] pm_data,      // program word, valid in the same cycle as pm_addr
  output logic                 fetch_hold,   // core must hold instruction fetch
  output logic                 tbl_done,     // table read finished, one cycle
  input  wire logic            dm_en,        // data access strobe
  input  wire logic [1:0]      dm_op,        // op_e: write, bit set, bit clear
  input  wire logic [7:0]      dm_addr,      // direct data address
  input  wire logic [2:0]      dm_bit,       // bit index for set and clear
  input  wire logic [7:0]      dm_wdata,     // write data
  output logic      [7:0]      dm_rdata,     // read data, combinational from the address
  output logic      [7:0]      table_high_byte // last fetched upper byte
);

  localparam logic [PC_W-1:0] PC_ONES = '1;

  tbl_state_e      state_q;
  logic [7:0]      table_pointer_q;
  logic [7:0]      memory_pointer_zero_q;
  logic [7:0]      memory_pointer_one_q;
  logic [7:0]      bank_q;
  logic [7:0]      eeprom_access_control_q;
  logic [7:0]      thigh_q;
  logic [7:0]      gp_mem [GP_DEPTH];
  logic [PC_W-1:0] taddr_d;
  logic [PC_W-1:0] taddr_q;
  logic [7:0]      tdst_q;
  logic [7:0]      eff_addr;
  logic            eff_bank1;
  logic            eff_null;
  logic [7:0]      rd_byte;
  logic [7:0]      wr_byte;
  logic            wr_en;
  logic [7:0]      wr_addr;
  logic            wr_bank1;
  logic [7:0]      fetched_hi;

  // table address from page select and pointer
  always_comb begin
    if (tbl_last) begin
      taddr_d = {PC_ONES[PC_W-1:TP_W], table_pointer_q};
    end else begin
      taddr_d = {pc[PC_W-1:TP_W], table_pointer_q};
    end
  end

  // two-cycle sequencer; the second cycle owns the program port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      taddr_q <= '0;
      tdst_q  <= ZERO_BYTE;
    end else if (clk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          if (tbl_rd) begin
            state_q <= ST_FETCH;
            taddr_q <= taddr_d;
            tdst_q  <= tbl_dst;
          end
        end
        // a request seen here is dropped; the core never issues one mid-fetch
        ST_FETCH: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign fetch_hold = (state_q == ST_FETCH);
  assign pm_addr    = (state_q == ST_FETCH) ? taddr_q : pc;
  assign tbl_done   = (state_q == ST_FETCH) && clk_en;

  // unimplemented word bits forced low
  assign fetched_hi = {{(PM_W-PW_W){1'b0}}, pm_data[PW_W-1:8]};

  // effective address: direct, or through a pointer for the indirect slots
  // pointer one alone can see bank 1; pointer zero always lands in bank 0
  always_comb begin
    eff_addr  = dm_addr;
    eff_bank1 = 1'b0;
    eff_null  = 1'b0;
    if (dm_addr == ADR_IND0) begin
      eff_addr = memory_pointer_zero_q;
    end else if (dm_addr == ADR_IND1) begin
      eff_addr  = memory_pointer_one_q;
      eff_bank1 = bank_q[0];
    end
    // indirect through an indirect slot does nothing
    if ((dm_addr == ADR_IND0 || dm_addr == ADR_IND1) &&
        (eff_addr == ADR_IND0 || eff_addr == ADR_IND1)) begin
      eff_null = 1'b1;
    end
  end

  // read mux; unused locations return zero
  // bank 1 has a single byte, any other bank 1 address reads zero
  always_comb begin
    rd_byte = ZERO_BYTE;
    if (eff_null) begin
      rd_byte = ZERO_BYTE;
    end else if (eff_bank1) begin
      if (eff_addr == ADR_EEACC) begin
        rd_byte = eeprom_access_control_q;
      end
    end else if (eff_addr >= ADR_GP_START && eff_addr < ADR_GP_START + 8'(GP_DEPTH)) begin
      rd_byte = gp_mem[6'(eff_addr - ADR_GP_START)];
    end else begin
      unique case (eff_addr)
        ADR_MPTR0: rd_byte = memory_pointer_zero_q;
        ADR_MPTR1: rd_byte = memory_pointer_one_q;
        ADR_BANKP: rd_byte = bank_q;
        ADR_TPTR:  rd_byte = table_pointer_q;
        ADR_THIGH: rd_byte = thigh_q;
        default:   rd_byte = ZERO_BYTE;
      endcase
    end
  end
  assign dm_rdata = rd_byte;

  // write path: table low byte wins over a core write in the same cycle
  // the core is held during the fetch, so the dropped write is never a real one
  always_comb begin
    wr_en    = 1'b0;
    wr_addr  = eff_addr;
    wr_bank1 = eff_bank1;
    wr_byte  = dm_wdata;
    if (state_q == ST_FETCH) begin
      wr_en    = 1'b1;
      wr_addr  = tdst_q;
      wr_bank1 = 1'b0;
      wr_byte  = pm_data[7:0];
    end else if (dm_en && !eff_null) begin
      unique case (op_e'(dm_op))
        OP_WR:   begin wr_en = 1'b1; wr_byte = dm_wdata; end
        OP_BSET: begin wr_en = 1'b1; wr_byte = rd_byte | (8'h01 << dm_bit); end
        OP_BCLR: begin wr_en = 1'b1; wr_byte = rd_byte & ~(8'h01 << dm_bit); end
        OP_NONE: wr_en = 1'b0;
      endcase
    end
  end

  // special registers; table high byte has no software write path
  // protected and unused slots fall to the default and keep nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memory_pointer_zero_q   <= MPTR_RESET;
      memory_pointer_one_q    <= MPTR_RESET;
      bank_q                  <= ZERO_BYTE;
      table_pointer_q         <= ZERO_BYTE;
      eeprom_access_control_q <= EEACC_RESET;
    end else if (clk_en && wr_en) begin
      if (wr_bank1) begin
        if (wr_addr == ADR_EEACC) begin
          eeprom_access_control_q <= wr_byte;
        end
      end else begin
        unique case (wr_addr)
          ADR_MPTR0: memory_pointer_zero_q <= wr_byte;
          ADR_MPTR1: memory_pointer_one_q  <= wr_byte;
          ADR_BANKP: bank_q                <= wr_byte;
          ADR_TPTR:  table_pointer_q       <= wr_byte;
          default:   ;
        endcase
      end
    end
  end

  // table high byte: loaded only by the table fetch
  // a later table read, e.g. from an interrupt, overwrites it for good
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thigh_q <= ZERO_BYTE;
    end else if (clk_en && state_q == ST_FETCH) begin
      thigh_q <= fetched_hi;
    end
  end
  assign table_high_byte = thigh_q;

  // general purpose bytes; no reset, plain ram
  always_ff @(posedge clk) begin
    if (clk_en && wr_en && !wr_bank1 &&
        wr_addr >= ADR_GP_START && wr_addr < ADR_GP_START + 8'(GP_DEPTH)) begin
      gp_mem[6'(wr_addr - ADR_GP_START)] <= wr_byte;
    end
  end

  // table sequencer checks, plus the unused-location and bit-set checks
  sequence s_start;
    clk_en && state_q == ST_IDLE && tbl_rd;
  endsequence

  sequence s_fetch;
    fetch_hold && pm_addr == $past(taddr_d);
  endsequence

  sequence s_stall;
    fetch_hold && !clk_en;
  endsequence

  chk_last_page_addr: assert property (@(posedge clk) disable iff (!arst_n)
    (s_start and tbl_last) |=> pm_addr[PC_W-1:TP_W] == PC_ONES[PC_W-1:TP_W])
    else $error("last page address not forced high");

  chk_cur_page_addr: assert property (@(posedge clk) disable iff (!arst_n)
    (s_start and !tbl_last) |=> pm_addr[PC_W-1:TP_W] == $past(pc[PC_W-1:TP_W]))
    else $error("current page address wrong");

  chk_tbl_two_cycles: assert property (@(posedge clk) disable iff (!arst_n)
    s_start |=> s_fetch ##1 (!fetch_hold || !$past(clk_en)))
    else $error("table read not two cycles");

  chk_low_ptr: assert property (@(posedge clk) disable iff (!arst_n)
    s_start |=> pm_addr[TP_W-1:0] == $past(table_pointer_q))
    else $error("table pointer not on low address bits");

  chk_thigh_load: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && fetch_hold) |=> thigh_q == $past(fetched_hi))
    else $error("table high byte not loaded");

  chk_thigh_ro: assert property (@(posedge clk) disable iff (!arst_n)
    !fetch_hold |=> $stable(thigh_q))
    else $error("table high byte changed outside a fetch");

  chk_thigh_msb_zero: assert property (@(posedge clk) disable iff (!arst_n)
    thigh_q[7:PW_W-8] == '0)
    else $error("unimplemented high bit set");

  chk_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (!dm_addr[7] && dm_addr >= ADR_SFR_END && dm_addr < ADR_GP_START) |-> dm_rdata == ZERO_BYTE)
    else $error("unused location not zero");

  chk_bit_set: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && !fetch_hold && dm_en && dm_op == OP_BSET && dm_addr == ADR_MPTR1)
      |=> memory_pointer_one_q == ($past(memory_pointer_one_q) | (8'h01 << $past(dm_bit))))
    else $error("bit set disturbed other bits");

  chk_stall_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_stall |=> fetch_hold && $stable(pm_addr) && $stable(thigh_q))
    else $error("table read advanced while enable low");

  chk_done_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    tbl_done |=> !tbl_done)
    else $error("done pulse longer than one cycle");

  chk_pm_addr_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !fetch_hold |-> pm_addr == pc)
    else $error("program port not on the counter outside a fetch");

  chk_tbl_low_write: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && fetch_hold && tdst_q >= ADR_GP_START && tdst_q < ADR_GP_START + 8'(GP_DEPTH))
      |=> gp_mem[6'($past(tdst_q) - ADR_GP_START)] == $past(pm_data[7:0]))
    else $error("table low byte not written to target");

  // data map checks
  chk_thigh_sw_write: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && !fetch_hold && dm_en && dm_op == OP_WR && dm_addr == ADR_THIGH) |=> $stable(thigh_q))
    else $error("software write reached the table high byte");

  chk_bank1_only: assert property (@(posedge clk) disable iff (!arst_n)
    (dm_addr == ADR_IND1 && bank_q[0] && memory_pointer_one_q != ADR_EEACC)
      |-> dm_rdata == ZERO_BYTE)
    else $error("bank 1 location other than eeprom control not zero");

  chk_ind_zero_read: assert property (@(posedge clk) disable iff (!arst_n)
    (dm_addr == ADR_IND0 && memory_pointer_zero_q >= ADR_GP_START &&
     memory_pointer_zero_q < ADR_GP_START + 8'(GP_DEPTH))
      |-> dm_rdata == gp_mem[6'(memory_pointer_zero_q - ADR_GP_START)])
    else $error("pointer zero read not from its target");

  chk_bit_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && !fetch_hold && dm_en && dm_op == OP_BCLR && dm_addr == ADR_MPTR1)
      |=> memory_pointer_one_q == ($past(memory_pointer_one_q) & ~(8'h01 << $past(dm_bit))))
    else $error("bit clear disturbed other bits");

endmodule
`default_nettype wire

// ### hw/tbl_dmem_pkg.sv
// constants for the table-read path and data-memory map
package tbl_dmem_pkg;
  localparam int          PC_W          = 12;        // program counter width of the variant (12, 11 or 10)
  localparam int          PW_W          = 15;        // implemented program word width
  localparam int          PM_W          = 16;        // program memory data port width
  localparam int          TP_W          = 8;         // table pointer width
  localparam logic [7:0]  ADR_IND0      = 8'h00;     // indirect access through pointer zero
  localparam logic [7:0]  ADR_MPTR0     = 8'h01;     // memory pointer zero
  localparam logic [7:0]  ADR_IND1      = 8'h02;     // indirect access through pointer one
  localparam logic [7:0]  ADR_MPTR1     = 8'h03;     // memory pointer one
  localparam logic [7:0]  ADR_BANKP     = 8'h04;     // bank select
  localparam logic [7:0]  ADR_TPTR      = 8'h07;     // table pointer
  localparam logic [7:0]  ADR_THIGH     = 8'h08;     // table high byte, read only
  localparam logic [7:0]  ADR_EEACC     = 8'h40;     // eeprom access control, bank 1
  localparam logic [7:0]  ADR_SFR_END   = 8'h28;     // first address past the special registers
  localparam logic [7:0]  ADR_GP_START  = 8'h40;     // first general purpose location in bank 0
  localparam int          GP_DEPTH      = 64;        // general purpose bytes
  localparam logic [7:0]  MPTR_RESET    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;     // value of unused locations
  localparam logic [7:0]  EEACC_RESET   = 8'h00;
  localparam int          TBL_CYCLES    = 2;         // instruction cycles of a table read
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_BSET = 2'b01,
    OP_BCLR = 2'b11,
    OP_WR   = 2'b10
  } op_e;
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_FETCH = 1'b1
  } tbl_state_e;
endpackage

// ### verification/tb_table_read_and_data_memory_map.sv
// self-checking bench for the table-read sequencer and banked data memory
`timescale 1ns/1ps
`default_nettype none
module tb_table_read_and_data_memory_map;
  import tbl_dmem_pkg::*;
  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  logic            clk_en = 1'b1;
  logic [PC_W-1:0] pc = '0;
  logic            tbl_rd = 1'b0;
  logic            tbl_last = 1'b0;
  logic [7:0]      tbl_dst = 8'h00;
  logic [PC_W-1:0] pm_addr;
  logic [PM_W-1:0] pm_data;
  logic            fetch_hold;
  logic            tbl_done;
  logic            dm_en = 1'b0;
  logic [1:0]      dm_op = 2'b00;
  logic [7:0]      dm_addr = 8'h00;
  logic [2:0]      dm_bit = 3'h0;
  logic [7:0]      dm_wdata = 8'h00;
  logic [7:0]      dm_rdata;
  logic [7:0]      table_high_byte;
  logic            rd_chk = 1'b0;
  logic [12:0]     exp_q[$];   // {is_table, value}
  logic [7:0]      gp[64];     // model of general ram
  int              err_total = 0;
  int              n_checks = 0;
  integer          seed = 32'h6ad8_e29f;

  always #2 clk = ~clk;
  // program word from its address; top bit set on some words so masking shows
  assign pm_data = {pm_addr[3:0] ^ 4'h9, pm_addr};

  tbl_dmem dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pc(pc), .tbl_rd(tbl_rd), .tbl_last(tbl_last),
    .tbl_dst(tbl_dst), .pm_addr(pm_addr), .pm_data(pm_data), .fetch_hold(fetch_hold), .tbl_done(tbl_done),
    .dm_en(dm_en), .dm_op(dm_op), .dm_addr(dm_addr), .dm_bit(dm_bit), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata), .table_high_byte(table_high_byte));

  // compare the oldest note mid-cycle, where combinational outputs have settled
  always @(negedge clk) begin : watch
    logic [12:0] e;
    if (rd_chk || tbl_done) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 13'h1fff;
      n_checks++;
      if (tbl_done && !(e[12] === 1'b1 && pm_addr === e[11:0] && fetch_hold === 1'b1)) begin
        $display("Error pm_addr exp %h got %h hold %b", e[11:0], pm_addr, fetch_hold);
        err_total++;
      end else if (rd_chk && !(e[12] === 1'b0 && dm_rdata === e[7:0] && fetch_hold === 1'b0)) begin
        $display("Error dm_rdata at %h exp %h got %h", dm_addr, e[7:0], dm_rdata);
        err_total++;
      end
      if (rd_chk && pm_addr !== pc) begin
        $display("Error pm_addr idle exp %h got %h", pc, pm_addr);
        err_total++;
      end
      if (rd_chk && dm_addr == ADR_THIGH && table_high_byte !== e[7:0]) begin
        $display("Error table_high_byte exp %h got %h", e[7:0], table_high_byte);
        err_total++;
      end
    end
  end

  // one data-side cycle; reads note the expected byte
  task automatic drive(input logic en, input logic [1:0] op, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] d, input logic rd, input logic [7:0] e);
    @(posedge clk);
    dm_en <= en;
    dm_op <= op;
    dm_addr <= a;
    dm_bit <= b;
    dm_wdata <= d;
    rd_chk <= rd;
    if (rd) exp_q.push_back({5'h00, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, OP_WR, a, 3'h0, d, 1'b0, 8'h00);
    if (a >= 8'h40 && a < 8'h80) gp[a - 8'h40] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    drive(1'b0, OP_NONE, a, 3'h0, 8'h00, 1'b1, e);
  endtask

  // table read: pointer set, request, then target and high byte read back
  // one table read at a time, high byte read back before the next can overwrite it
  task automatic tbl(input logic last, input logic [7:0] dst, input logic [7:0] tp);
    logic [PC_W-1:0] pcv;
    logic [PC_W-1:0] ta;
    logic [15:0]     w;
    logic            stall;
    pcv = PC_W'($random(seed));
    ta = last ? {{(PC_W-8){1'b1}}, tp} : {pcv[PC_W-1:8], tp};
    w = {ta[3:0] ^ 4'h9, ta};
    wr(ADR_TPTR, tp);
    @(posedge clk);
    dm_en <= 1'b0;
    dm_op <= OP_NONE;
    pc <= pcv;
    tbl_rd <= 1'b1;
    tbl_last <= last;
    tbl_dst <= dst;
    exp_q.push_back({1'b1, ta});
    @(posedge clk);
    tbl_rd <= 1'b0;
    // sometimes freeze the fetch cycle for one clock
    stall = 1'($random(seed));
    clk_en <= !stall;
    if (stall) begin
      @(posedge clk);
      clk_en <= 1'b1;
    end
    gp[dst - 8'h40] = w[7:0];
    rd(dst, w[7:0]);
    rd(ADR_THIGH, {1'b0, w[14:8]});
    wr(ADR_THIGH, ~{1'b0, w[14:8]});
    rd(ADR_THIGH, {1'b0, w[14:8]});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #200_000;
    err_total++;
    complete_run();
  end

  initial begin : main
    logic [7:0] a;
    logic [7:0] v;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADR_MPTR0, MPTR_RESET);
    rd(ADR_THIGH, ZERO_BYTE);
    for (int i = 9; i < 64; i++) begin
      wr(i[7:0], 8'hff);
      rd(i[7:0], ZERO_BYTE);
    end
    for (int i = 0; i < 64; i++) wr(8'h40 + i[7:0], 8'($random(seed)));
    for (int i = 0; i < 64; i++) rd(8'h40 + i[7:0], gp[i]);
    // a write under a low enable must not land
    drive(1'b1, OP_WR, 8'h7f, 3'h0, ~gp[63], 1'b0, 8'h00);
    clk_en <= 1'b0;
    rd(8'h7f, gp[63]);
    clk_en <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      a = 8'h40 | 8'($random(seed) & 63);
      v = gp[a - 8'h40];
      drive(1'b1, OP_BSET, a, b[2:0], 8'h00, 1'b0, 8'h00);
      rd(a, v | 8'(1 << b));
      drive(1'b1, OP_BCLR, a, b[2:0], 8'h00, 1'b0, 8'h00);
      gp[a - 8'h40] = v & ~8'(1 << b);
      rd(a, gp[a - 8'h40]);
    end
    // indirect slots, including a pointer aimed back at a slot
    wr(ADR_MPTR0, 8'h45);
    rd(ADR_IND0, gp[5]);
    wr(ADR_IND0, 8'h3c);
    gp[5] = 8'h3c;
    rd(8'h45, 8'h3c);
    wr(ADR_MPTR1, 8'h50);
    drive(1'b1, OP_BSET, ADR_MPTR1, 3'h1, 8'h00, 1'b0, 8'h00);
    drive(1'b1, OP_BCLR, ADR_MPTR1, 3'h1, 8'h00, 1'b0, 8'h00);
    rd(ADR_MPTR1, 8'h50);
    rd(ADR_IND1, gp[16]);
    wr(ADR_MPTR1, ADR_IND0);
    rd(ADR_IND1, ZERO_BYTE);
    // bank 1 holds only the eeprom control byte; pointer zero ignores the bank
    wr(ADR_BANKP, 8'h01);
    wr(ADR_MPTR1, 8'h45);
    rd(ADR_IND1, ZERO_BYTE);
    wr(ADR_MPTR1, ADR_EEACC);
    rd(ADR_IND1, EEACC_RESET);
    wr(ADR_IND1, 8'ha5);
    rd(ADR_IND1, 8'ha5);
    wr(ADR_MPTR0, 8'h40);
    rd(ADR_IND0, gp[0]);
    wr(ADR_BANKP, 8'h00);
    rd(ADR_IND1, gp[0]);
    for (int k = 0; k < 8; k++) tbl(k[0], 8'h40 | 8'($random(seed) & 63), 8'($random(seed)));
    // idle cycle so the watcher stops reading before the end
    drive(1'b0, OP_NONE, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
